/* adc_conv_ctl_sva.sv */
// checker on the bus and converter outputs of the top module
module adc_conv_ctl_sva (
  input logic        sys_clk,
  input logic        rst_n,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [4:0]  channel_select,
  input logic        channel_valid,
  input logic        ref_use_pin,
  input logic        ref_valid,
  input logic        converter_on,
  input logic        sample_hold,
  input logic        wake_req,
  input logic        conv_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_chan_valid: assert property (channel_valid == (channel_select <= 5'h04 || channel_select == 5'h1d ||
    channel_select == 5'h1f || (channel_select >= 5'h08 && channel_select <= 5'h0d)))
    else $error("channel valid wrong");
  a_ref_pin: assert property (ref_use_pin |-> ref_valid)
    else $error("pin reference not valid");
  a_off_quiet: assert property (!converter_on [*2] |-> !sample_hold)
    else $error("sampling while converter off");
  a_wake_irq: assert property (wake_req |-> conv_irq)
    else $error("wake without interrupt");
endmodule
bind adc_conversion_control adc_conv_ctl_sva i_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .channel_select(channel_select),
  .channel_valid(channel_valid), .ref_use_pin(ref_use_pin), .ref_valid(ref_valid),
  .converter_on(converter_on), .sample_hold(sample_hold), .wake_req(wake_req), .conv_irq(conv_irq));

/* adc_conv_defs.svh */
`ifndef ADC_CONV_DEFS_SVH
`define ADC_CONV_DEFS_SVH
// register byte offsets
`define ADC_OFF_CTRL 8'h00
`define ADC_OFF_CFG 8'h04
`define ADC_OFF_RESH 8'h08
`define ADC_OFF_RESL 8'h0c
`define ADC_OFF_STAT 8'h10
// conversion_control fields
`define ADC_EN_BIT 0
`define ADC_GO_BIT 1
`define ADC_CHS_LSB 2
`define ADC_CHS_MSB 6
// conversion_config fields
`define ADC_JUST_BIT 7
`define ADC_CKS_LSB 4
`define ADC_CKS_MSB 6
`define ADC_PREF_LSB 0
`define ADC_PREF_MSB 1
// status fields
`define ADC_DONE_BIT 0
`define ADC_IE_BIT 1
`define ADC_OFF_STATE_BIT 2
// reset values
`define ADC_CTRL_RST 8'h00
`define ADC_CFG_RST 8'h00
`define ADC_RES_RST 8'h00
// channel codes
`define ADC_CH_AN4 5'h04
`define ADC_CH_AN8 5'h08
`define ADC_CH_AN13 5'h0d
`define ADC_CH_TEMP 5'h1d
`define ADC_CH_FVR 5'h1f
// reference codes
`define ADC_REF_VDD 2'h0
`define ADC_REF_PIN 2'h2
// timing: system period and instruction cycle in ns
`define ADC_SYS_NS 10
`define ADC_INSTR_NS 40
`define ADC_START_DLY ((`ADC_INSTR_NS + `ADC_SYS_NS - 1) / `ADC_SYS_NS)
// a conversion lasts 11.5 tad, counted in half tad
`define ADC_HALF_TADS 23
`define ADC_FIRST_DECIDE 3
// half tad in system cycles per divider code
`define ADC_HALF_DIV2 6'h01
`define ADC_HALF_DIV4 6'h02
`define ADC_HALF_DIV8 6'h04
`define ADC_HALF_DIV16 6'h08
`define ADC_HALF_DIV32 6'h10
`define ADC_HALF_DIV64 6'h20
`define ADC_RESP_OK 2'h0
`define ADC_RESP_ERR 2'h2
`endif

/* adc_conv_pkg.sv */
package adc_conv_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONV
  } conv_state_e;
endpackage

/* adc_conversion_control.sv */
`include "adc_conv_defs.svh"
module adc_conversion_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep_active,
  input  wire logic        cmp_in,
  input  wire logic        rc_osc,
  output logic             converter_on,
  output logic [4:0]       channel_select,
  output logic             channel_valid,
  output logic             ref_use_pin,
  output logic             ref_valid,
  output logic             sample_hold,
  output logic [9:0]       dac_code,
  output logic             conv_irq,
  output logic             wake_req
);
  import adc_conv_pkg::*;

  conv_state_e state_q;
  logic        enable_q;
  logic        go_q;
  logic [4:0]  chan_q;
  logic        justify_q;
  logic [2:0]  clksel_q;
  logic [1:0]  pref_q;
  logic [7:0]  res_hi_q;
  logic [7:0]  res_lo_q;
  logic        done_q;
  logic        ie_q;
  logic        sleep_off_q;
  logic [9:0]  sar_q;
  logic [3:0]  idx_q;
  logic        last_q;
  logic [4:0]  half_q;
  logic [5:0]  div_q;
  logic [2:0]  dly_q;
  logic        aw_have_q;
  logic [7:0]  aw_addr_q;
  logic        w_have_q;
  logic [7:0]  w_data_q;
  logic        w_lane_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        cmp_s1_q;
  logic        cmp_s2_q;
  logic        rc_s1_q;
  logic        rc_s2_q;
  logic        rc_s3_q;
  logic        on_q;
  logic        irq_q;
  logic        wake_q;
  logic        hold_q;

  logic        wr_fire;
  logic        wr_ctrl;
  logic        wr_cfg;
  logic        wr_resh;
  logic        wr_resl;
  logic        wr_stat;
  logic [7:0]  wd;
  logic        rc_sel;
  logic        half_tick;
  logic [5:0]  half_len;
  logic        start_req;
  logic        stop_req;
  logic        kill_req;
  logic        decide;
  logic        complete;
  logic [9:0]  sar_dec;
  logic [9:0]  partial;
  logic [9:0]  result;
  logic        load_res;
  logic [7:0]  rd_mux;
  logic        rd_hit;
  logic        wr_hit;

  // external pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      rc_s1_q  <= 1'b0;
      rc_s2_q  <= 1'b0;
      rc_s3_q  <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_in;
      cmp_s2_q <= cmp_s1_q;
      rc_s1_q  <= rc_osc;
      rc_s2_q  <= rc_s1_q;
      rc_s3_q  <= rc_s2_q;
    end
  end

  // axi write channels, address and data taken in either order
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign wd = w_data_q;
  assign wr_hit = (aw_addr_q == `ADC_OFF_CTRL) | (aw_addr_q == `ADC_OFF_CFG) |
                  (aw_addr_q == `ADC_OFF_RESH) | (aw_addr_q == `ADC_OFF_RESL) |
                  (aw_addr_q == `ADC_OFF_STAT);
  // only byte lane 0 carries register bits
  assign wr_ctrl = wr_fire & w_lane_q & (aw_addr_q == `ADC_OFF_CTRL);
  assign wr_cfg  = wr_fire & w_lane_q & (aw_addr_q == `ADC_OFF_CFG);
  assign wr_resh = wr_fire & w_lane_q & (aw_addr_q == `ADC_OFF_RESH);
  assign wr_resl = wr_fire & w_lane_q & (aw_addr_q == `ADC_OFF_RESL);
  assign wr_stat = wr_fire & w_lane_q & (aw_addr_q == `ADC_OFF_STAT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `ADC_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `ADC_RESP_OK : `ADC_RESP_ERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // read mux; spare bits read as zero
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 8'h00;
    case (s_axi_araddr)
      `ADC_OFF_CTRL: rd_mux = {1'b0, chan_q, go_q, enable_q};
      `ADC_OFF_CFG:  rd_mux = {justify_q, clksel_q, 2'h0, pref_q};
      `ADC_OFF_RESH: rd_mux = res_hi_q;
      `ADC_OFF_RESL: rd_mux = res_lo_q;
      `ADC_OFF_STAT: rd_mux = {5'h00, sleep_off_q, ie_q, done_q};
      default:       rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = ~rvalid_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `ADC_RESP_OK;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_mux};
      rresp_q  <= rd_hit ? `ADC_RESP_OK : `ADC_RESP_ERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // enable, channel and configuration fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q  <= 1'b0;
      chan_q    <= 5'h00;
      justify_q <= 1'b0;
      clksel_q  <= 3'h0;
      pref_q    <= 2'h0;
      ie_q      <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        enable_q <= wd[`ADC_EN_BIT];
        chan_q   <= wd[`ADC_CHS_MSB:`ADC_CHS_LSB];
      end
      if (wr_cfg) begin
        justify_q <= wd[`ADC_JUST_BIT];
        clksel_q  <= wd[`ADC_CKS_MSB:`ADC_CKS_LSB];
        pref_q    <= wd[`ADC_PREF_MSB:`ADC_PREF_LSB];
      end
      if (wr_stat) begin
        ie_q <= wd[`ADC_IE_BIT];
      end
    end
  end

  // x11 selects the rc clock, the rest divide sys_clk
  assign rc_sel = clksel_q[1] & clksel_q[0];
  always_comb begin
    case (clksel_q)
      3'h0:    half_len = `ADC_HALF_DIV2;
      3'h4:    half_len = `ADC_HALF_DIV4;
      3'h1:    half_len = `ADC_HALF_DIV8;
      3'h5:    half_len = `ADC_HALF_DIV16;
      3'h2:    half_len = `ADC_HALF_DIV32;
      3'h6:    half_len = `ADC_HALF_DIV64;
      default: half_len = `ADC_HALF_DIV2;
    endcase
  end

  // both rc edges count as half tad; divider restarts per conversion
  assign half_tick = rc_sel ? (rc_s2_q ^ rc_s3_q) : (div_q == half_len - 6'h01);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 6'h00;
    end else if (state_q != ST_CONV || half_tick) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // go only counts when already enabled by an earlier write
  assign start_req = wr_ctrl & wd[`ADC_GO_BIT] & wd[`ADC_EN_BIT] & enable_q &
                     ~sleep_off_q & (state_q == ST_IDLE);
  assign stop_req = wr_ctrl & ~wd[`ADC_GO_BIT] & (state_q != ST_IDLE);
  // disable or sleep on a divided clock kills without a result
  assign kill_req = (wr_ctrl & ~wd[`ADC_EN_BIT]) |
                    (sleep_active & ~rc_sel);
  assign decide = (state_q == ST_CONV) & half_tick & half_q[0] &
                  (half_q >= 5'(`ADC_FIRST_DECIDE));
  assign complete = (state_q == ST_CONV) & half_tick &
                    (half_q == 5'(`ADC_HALF_TADS - 1));

  // successive approximation trial for the present bit
  always_comb begin
    sar_dec = sar_q;
    sar_dec[idx_q] = cmp_s2_q;
    if (idx_q != 4'h0) begin
      sar_dec[idx_q - 4'h1] = 1'b1;
    end
  end

  // undecided bits copy the last decided one
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_fill
      assign partial[gi] = (4'(gi) > idx_q || idx_q > 4'h9) ? sar_q[gi] : last_q;
    end
  endgenerate

  assign load_res = complete | (stop_req & ~kill_req);
  assign result = complete ? sar_q : partial;

  // conversion sequencer, go bit and result registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      go_q     <= 1'b0;
      sar_q    <= 10'h000;
      idx_q    <= 4'h0;
      last_q   <= 1'b0;
      half_q   <= 5'h00;
      dly_q    <= 3'h0;
      res_hi_q <= `ADC_RES_RST;
      res_lo_q <= `ADC_RES_RST;
    end else begin
      if (wr_resh) begin
        res_hi_q <= wd;
      end
      if (wr_resl) begin
        res_lo_q <= wd;
      end
      if (kill_req && state_q != ST_IDLE) begin
        state_q <= ST_IDLE;
        go_q    <= 1'b0;
      end else if (load_res) begin
        state_q <= ST_IDLE;
        go_q    <= 1'b0;
        if (justify_q) begin
          res_hi_q <= {6'h00, result[9:8]};
          res_lo_q <= result[7:0];
        end else begin
          res_hi_q <= result[9:2];
          res_lo_q <= {result[1:0], 6'h00};
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start_req) begin
              go_q   <= 1'b1;
              sar_q  <= 10'h200;
              idx_q  <= 4'h9;
              last_q <= 1'b0;
              half_q <= 5'h00;
              dly_q  <= 3'(`ADC_START_DLY - 1);
              state_q <= rc_sel ? ST_DELAY : ST_CONV;
            end
          end
          ST_DELAY: begin
            if (dly_q == 3'h0) begin
              state_q <= ST_CONV;
            end else begin
              dly_q <= dly_q - 3'h1;
            end
          end
          ST_CONV: begin
            if (half_tick) begin
              half_q <= half_q + 5'h01;
            end
            if (decide) begin
              sar_q  <= sar_dec;
              idx_q  <= idx_q - 4'h1;
              last_q <= cmp_s2_q;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // done flag: hardware sets, only software clears, set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (complete && !kill_req) begin
      done_q <= 1'b1;
    end else if (wr_stat && wd[`ADC_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // analog power-down in sleep on a divided clock, or on rc after a conversion with ie clear; lifted when sleep ends
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_off_q <= 1'b0;
    end else if (!sleep_active) begin
      sleep_off_q <= 1'b0;
    end else if (!rc_sel) begin
      sleep_off_q <= 1'b1;
    end else if (complete && !ie_q) begin
      sleep_off_q <= 1'b1;
    end
  end

  // registered analog and system controls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_q   <= 1'b0;
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      on_q   <= enable_q & ~sleep_off_q;
      irq_q  <= done_q & ie_q;
      wake_q <= sleep_active & rc_sel & done_q & ie_q;
      hold_q <= (state_q == ST_CONV);
    end
  end

  // channel and reference routing
  always_comb begin
    channel_valid = (chan_q <= `ADC_CH_AN4) |
                    (chan_q >= `ADC_CH_AN8 && chan_q <= `ADC_CH_AN13) |
                    (chan_q == `ADC_CH_TEMP) |
                    (chan_q == `ADC_CH_FVR);
  end
  assign channel_select = chan_q;
  assign ref_use_pin = (pref_q == `ADC_REF_PIN);
  assign ref_valid = (pref_q == `ADC_REF_PIN) | (pref_q == `ADC_REF_VDD);
  assign converter_on = on_q;
  assign conv_irq = irq_q;
  assign wake_req = wake_q;
  assign sample_hold = hold_q;
  assign dac_code = sar_q;

endmodule

/* tb.sv */
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdv;
  logic [1:0]  bresp, rresp, rrs, brs;
  logic        awr, wrdy, bv, arr, rv, sleep = 0, cmp = 0, rc = 0, rc_on = 0;
  logic [31:0] rdata;
  logic [4:0]  chs;
  logic [9:0]  dac;
  logic        con, chv, rpin, rval, sh, irq, wake;
  logic [1:0]  rc_div = 0;
  int          n_fail = 0, checked = 0;
  adc_conversion_control i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .sleep_active(sleep), .cmp_in(cmp), .rc_osc(rc), .converter_on(con), .channel_select(chs),
    .channel_valid(chv), .ref_use_pin(rpin), .ref_valid(rval), .sample_hold(sh), .dac_code(dac),
    .conv_irq(irq), .wake_req(wake));
  // clock; the rc oscillator only runs while a scenario asks for it
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rc_on) rc_div <= rc_div + 2'h1;
    rc <= rc_div[1];
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic timeout();
    n_fail++;
    final_report();
  endtask
  // one write; address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic ta, tw, tb_;
    tb_ = 0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 40 && !tb_; n++) begin
      @(negedge sys_clk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb_ = bv;
      brs = bresp;
      @(posedge sys_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    // bready stays high between writes, so back-to-back calls never toggle it in one step
    if (!tb_) timeout();
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic got, ta;
    got = 0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 40 && !got; n++) begin
      @(negedge sys_clk);
      got = rv;
      ta = arv && arr;
      rdv = rdata;
      rrs = rresp;
      @(posedge sys_clk);
      if (ta) arv <= 1'b0;
    end
    // rready stays high between reads
    if (!got) timeout();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK("register", e, rdv[7:0])
    `CHK("read resp", 2'h0, rrs)
  endtask
  // poll the busy bit as software would, with a bound
  task automatic wait_idle();
    int n;
    for (n = 0; n < 1000; n++) begin
      rd(8'h00);
      if (rdv[1] === 1'b0) break;
    end
    if (n == 1000) timeout();
  endtask
  task automatic reset_and_map();
    for (int i = 0; i < 5; i++) rchk(8'(i * 4), 8'h00);
    rd(8'h14);
    `CHK("unmapped resp", 2'h2, rrs)
    wr(8'h14, 8'h00);
    `CHK("unmapped wresp", 2'h2, brs)
    wr(8'h04, 8'hff);
    `CHK("write resp", 2'h0, brs)
    rchk(8'h04, 8'hf3);
    wr(8'h00, 8'hff);
    rchk(8'h00, 8'h7d);
  endtask
  task automatic fields();
    for (int c = 0; c < 32; c++) begin
      wr(8'h00, {1'b0, 5'(c), 2'h1});
      `CHK("chan valid", (c <= 4 || (c >= 8 && c <= 13) || c == 29 || c == 31), chv)
    end
    for (int p = 0; p < 4; p++) begin
      wr(8'h04, 8'(p));
      `CHK("ref valid", (p == 0 || p == 2), rval)
      `CHK("ref pin", (p == 2), rpin)
    end
  endtask
  task automatic full_conv(input logic [7:0] cfg, input logic [7:0] eh, input logic [7:0] el);
    wr(8'h04, cfg);
    wr(8'h00, 8'h01);
    wr(8'h00, 8'h03);
    rchk(8'h00, 8'h03);
    wait_idle();
    `CHK("dac", 10'h3ff, dac)
    rchk(8'h08, eh);
    rchk(8'h0c, el);
    rchk(8'h10, 8'h01);
    wr(8'h10, 8'h01);
    rchk(8'h10, 8'h00);
  endtask
  // length of the conversion, while sample_hold is high, for each divided conversion clock
  task automatic clk_codes();
    logic [2:0] cs[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    int len, h;
    for (int i = 0; i < 6; i++) begin
      h = 1 << i;
      len = 0;
      wr(8'h04, {1'b1, cs[i], 4'h0});
      wr(8'h00, 8'h03);
      for (int n = 0; n < 3000; n++) begin
        @(negedge sys_clk);
        if (sh) len++;
        else if (len > 0) break;
      end
      @(posedge sys_clk);
      `CHK("conv cycles", 1'b1, (len >= 23 * h - 4 && len <= 23 * h + 2))
    end
    wait_idle();
    wr(8'h10, 8'h01);
  endtask
  task automatic early_stop();
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h04, 8'he0);
    wr(8'h00, 8'h03);
    // comparator drops after the first decision, so a full run would differ
    repeat (150) @(posedge sys_clk);
    cmp <= 1'b0;
    repeat (20) @(posedge sys_clk);
    wr(8'h00, 8'h01);
    rchk(8'h00, 8'h01);
    rchk(8'h08, 8'h03);
    rchk(8'h0c, 8'hff);
    rchk(8'h10, 8'h00);
    cmp <= 1'b1;
  endtask
  task automatic sleep_abort();
    wr(8'h00, 8'h03);
    sleep <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("powered", 1'b0, con)
    rchk(8'h00, 8'h01);
    rchk(8'h10, 8'h04);
    sleep <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("powered", 1'b1, con)
  endtask
  // rc clock conversions in sleep, with and without the interrupt enable
  task automatic sleep_rc();
    for (int ie = 0; ie < 2; ie++) begin
      rc_on <= 1'b1;
      wr(8'h04, 8'hb0);
      wr(8'h10, {6'h0, 1'(ie), 1'b0});
      wr(8'h00, 8'h03);
      // rc start waits one instruction, so sampling has not begun yet
      @(posedge sys_clk);
      `CHK("start delay", 1'b0, sh)
      sleep <= 1'b1;
      wait_idle();
      repeat (3) @(posedge sys_clk);
      `CHK("wake", 1'(ie), wake)
      `CHK("irq", 1'(ie), irq)
      `CHK("powered", 1'(ie), con)
      rchk(8'h00, 8'h01);
      rchk(8'h08, 8'h03);
      sleep <= 1'b0;
      rc_on <= 1'b0;
      wr(8'h10, 8'h01);
    end
  endtask
  task automatic mid_reset();
    wr(8'h04, 8'he0);
    wr(8'h00, 8'h03);
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK("powered", 1'b0, con)
    rchk(8'h00, 8'h00);
    rchk(8'h08, 8'h00);
  endtask
  // main sequence: reset, then each scenario in turn
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    reset_and_map();
    fields();
    cmp <= 1'b1;
    full_conv(8'h80, 8'h03, 8'hff);
    full_conv(8'h00, 8'hff, 8'hc0);
    clk_codes();
    early_stop();
    sleep_abort();
    sleep_rc();
    mid_reset();
    final_report();
  end
endmodule
